// ===== srhc_pkg.sv
/*
 * Package for the suspend/resume/reset host controller: opcodes, timing,
 * register map of the controller's own Wishbone registers, and carriers.
 * Assumes a 250 MHz system clock.
 */
`default_nettype none
package srhc_pkg;
    localparam int CLK_MHZ = 250;
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_RST_ARM = 8'h66;
    localparam logic [7:0] OP_RST_EXEC = 8'h99;
    localparam logic [7:0] OP_PARAM_RD = 8'h5A;
    localparam logic [7:0] OP_PARAM_RD_INV = 8'hA5;
    localparam logic [7:0] OP_RESUME = 8'h30;
    localparam logic [7:0] OP_SUSPEND = 8'hB0;
    localparam logic [7:0] OP_WR_DIS = 8'h04;
    localparam logic [7:0] OP_STAT_RD = 8'h05;
    localparam logic [7:0] OP_CFG_RD = 8'h15;
    localparam logic [7:0] OP_SEC_RD = 8'h2B;
    localparam logic [7:0] OP_SIG_RD = 8'hAB;
    localparam logic [7:0] OP_CFG2_RD = 8'h71;
    localparam logic [7:0] OP_CFG2_WR = 8'h72;
    localparam logic [1:0] A_HI_FREE = 2'h2;
    localparam logic [1:0] A_HI_BLOCK = 2'h1;
    localparam int PSB_BIT = 2;
    localparam int ESB_BIT = 3;
    localparam int SPI_ADDR_BYTES = 3;
    localparam int OPI_ADDR_BYTES = 4;
    localparam int SPI_DUMMY = 8;
    localparam int OPI_DUMMY = 20;
    // Register offsets (byte addresses) and control bits
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h4;
    localparam logic [3:0] REG_STAT = 4'h8;
    localparam logic [3:0] REG_DATA = 4'hC;
    localparam int CTL_GO = 31;
    localparam int CTL_OCTAL = 30;
    localparam int CTL_SUSP_P = 29;
    localparam int CTL_SUSP_E = 28;
    localparam int CTL_LAT_OK = 27;
    localparam int CTL_DATA_HI = 15;
    localparam logic [7:0] CTL_CNT_MASK = 8'hFF;
    typedef enum logic [2:0] {
        SR_IDLE = 3'b000, SR_CMD = 3'b001, SR_ADDR = 3'b010,
        SR_DUMMY = 3'b011, SR_DATA = 3'b100, SR_WAIT = 3'b101
    } srhc_state_t;
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic [7:0] dout;
        logic [7:0] doe;
    } srhc_pins_t;
endpackage : srhc_pkg
`default_nettype wire

// ===== srhc_host.sv
/*
 * Host controller that issues single-line or octal-STR commands to the
 * flash, gating opcodes by suspend state and sequencing resets and
 * parameter reads. Software drives it over classic Wishbone.
 * Assumes the device pins are the only far side; no buffering.
 */
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// [RL1] Latency-bound opcodes wait for suspend latency
// [RL2] Free opcodes pass during suspend anytime
// [RL3] Second config access gated by address bits
// [RL4] Resume sets latch, busy, clears suspend flag
// [RL5] Resumed operation runs until done or suspended
// [RL6] Host waits resume-to-suspend time before suspending
// [RL7] After resume only suspend until operation time
// [RL8] Completion clears latch and busy
// [RL9] No-operation only cancels pending reset arm
// [RL10] Reset needs arm then execute commands
// [RL11] Other command between them cancels arm
// [RL12] Reset during program or erase aborts it
// [RL13] Host waits recovery time after reset
// [RL14] Single-line param read: 3 address, 8 dummy
// [RL15] Octal param read: opcode pair, 4 address, 20 dummy
// [RL16] Raising select ends data phase at once
// [RL17] Double-rate param read address must be even
// [RL18] After suspend latency latch clears, flag sets
// [RL19] Suspend flags at security bits 2 and 3
// [RL20] Unaccepted opcodes ignored while suspended
module srhc_host
    import srhc_pkg::*;
#(
    parameter int SCK_DIV = 4,
    parameter int RESUME_WAIT_US = 100,
    parameter int RESET_WAIT_US = 40,
    parameter int RESUME_CYC = RESUME_WAIT_US * CLK_MHZ,
    parameter int RESET_CYC = RESET_WAIT_US * CLK_MHZ
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic flash_sclk_o,
    output logic flash_cs_n_o,
    output logic [7:0] octal_data_lines_o,
    output logic [7:0] octal_data_lines_oe_o,
    input wire logic [7:0] octal_data_lines_i
);
    typedef struct packed {
        srhc_state_t st;
        srhc_pins_t pins;
        logic ack;
        logic [31:0] rdat;
        logic [31:0] ctrl;
        logic [31:0] addr;
        logic [31:0] data;
        logic [7:0] op;
        logic [7:0] left;
        logic [5:0] bitn;
        logic [7:0] sh;
        logic [3:0] div;
        logic reset_armed;
        logic rejected;
        logic program_suspend_flag;
        logic erase_suspend_flag;
        logic [31:0] wait_cnt;
        logic [7:0] s1;
        logic [7:0] s2;
    } srhc_reg_t;

    srhc_reg_t r, n;

    ////////////////////////////////////////////////////////////////////////////
    // Opcodes that need no suspend latency
    function automatic logic free_op(input logic [7:0] op, input logic [1:0] ahi);
        free_op = (op == OP_WR_DIS) || (op == OP_STAT_RD) || (op == OP_CFG_RD)
            || (op == OP_SEC_RD) || (op == OP_SIG_RD) || (op == OP_RST_ARM)
            || (op == OP_RST_EXEC) || (op == OP_NOP)
            || ((op == OP_CFG2_RD || op == OP_CFG2_WR) && ahi == A_HI_FREE);
    endfunction : free_op

    function automatic logic lat_op(input logic [7:0] op, input logic [1:0] ahi);
        case (op)
            8'h03, 8'h13, 8'h0B, 8'h0C, 8'hEC, 8'hEE, 8'h5A, 8'h9F, 8'hC0,
            8'hB1, 8'hC1, 8'h06, 8'h30, 8'h2D, 8'hE2, 8'h16, 8'hE0:
                lat_op = 1'b1;
            8'h71: lat_op = (ahi != A_HI_FREE) && (ahi[1] == 1'b0);
            8'h72: lat_op = (ahi == 2'h0);
            default: lat_op = 1'b0;
        endcase
    endfunction : lat_op

    logic susp;
    logic allowed;
    logic sck_tick;
    logic go_req;
    assign susp = r.program_suspend_flag || r.erase_suspend_flag;
    // Writes to second config with address bits 01 are never sent in suspend
    assign allowed = !susp || free_op(r.ctrl[7:0], r.addr[31:30])  // see [RL2] [RL3]
        || (r.ctrl[CTL_LAT_OK] && lat_op(r.ctrl[7:0], r.addr[31:30]));  // see [RL1] [RL20]
    assign sck_tick = (r.div == 4'(SCK_DIV - 1));
    assign go_req = wb_cyc_i && wb_stb_i && wb_we_i && !r.ack && wb_adr_i == REG_CTRL
        && wb_sel_i[3] && wb_dat_i[CTL_GO];

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        n = r;
        n.ack = wb_cyc_i && wb_stb_i && !r.ack;
        n.s1 = octal_data_lines_i;
        n.s2 = r.s1;
        n.div = sck_tick ? 4'h0 : r.div + 4'h1;
        if (wb_cyc_i && wb_stb_i && !r.ack) begin
            unique case (wb_adr_i)
                REG_CTRL: n.rdat = {r.st != SR_IDLE, r.ctrl[30:0]};
                REG_ADDR: n.rdat = r.addr;
                REG_STAT: n.rdat = {27'h0, r.rejected, r.erase_suspend_flag, r.program_suspend_flag,  // see [RL19]
                    r.reset_armed, r.st != SR_IDLE};
                REG_DATA: n.rdat = r.data;
                default: n.rdat = 32'h0;
            endcase
            if (wb_we_i && r.st == SR_IDLE) begin
                if (wb_adr_i == REG_CTRL && wb_sel_i == 4'hF) begin
                    n.ctrl = wb_dat_i;
                    n.ctrl[CTL_GO] = 1'b0;
                end
                if (wb_adr_i == REG_ADDR && wb_sel_i == 4'hF) begin
                    n.addr = wb_dat_i;
                end
                if (wb_adr_i == REG_STAT && wb_sel_i[0]) begin
                    n.program_suspend_flag = wb_dat_i[CTL_SUSP_P - 27];
                    n.erase_suspend_flag = wb_dat_i[CTL_SUSP_E - 25];
                    n.rejected = 1'b0;
                end
            end
        end
        unique case (r.st)
            SR_IDLE: begin
                n.pins.cs_n = 1'b1;
                n.pins.sclk = 1'b0;
                n.pins.doe = 8'h00;
                if (r.ctrl[CTL_GO]) begin
                    n.ctrl[CTL_GO] = 1'b0;
                    if (allowed) begin
                        n.op = r.ctrl[7:0];
                        // First bit or byte must stand before the first rising edge
                        n.sh = {r.ctrl[6:0], 1'b0};
                        n.pins.dout = r.ctrl[CTL_OCTAL] ? r.ctrl[7:0] : {7'h0, r.ctrl[7]};
                        n.pins.doe = r.ctrl[CTL_OCTAL] ? 8'hFF : 8'h01;
                        n.pins.cs_n = 1'b0;
                        n.bitn = r.ctrl[CTL_OCTAL] ? 6'd2 : 6'd8;  // see [RL15]
                        n.st = SR_CMD;
                        n.data = 32'h0;
                    end else begin
                        n.rejected = 1'b1;  // see [RL20]
                    end
                end
                if (go_req && wb_sel_i == 4'hF) begin
                    n.ctrl = wb_dat_i;
                end
            end
            SR_CMD, SR_ADDR, SR_DUMMY, SR_DATA: begin
                if (sck_tick) begin
                    n.pins.sclk = !r.pins.sclk;
                    if (!r.pins.sclk) begin
                        // Data is sampled on rising edges; synchronised copy used
                        if (r.st == SR_DATA) begin
                            n.data = r.ctrl[CTL_OCTAL] ? {r.data[23:0], r.s2}
                                : {r.data[30:0], r.s2[1]};  // see [RL14]
                        end
                    end else begin
                        n.bitn = r.bitn - 6'd1;
                        if (r.bitn == 6'd1) begin
                            unique case (r.st)
                                SR_CMD: begin
                                    if (r.op == OP_PARAM_RD) begin
                                        n.st = SR_ADDR;  // see [RL14] [RL15]
                                        n.bitn = r.ctrl[CTL_OCTAL] ? 6'(OPI_ADDR_BYTES)
                                            : 6'(SPI_ADDR_BYTES * 8);
                                        n.sh = r.addr[23:16];
                                    end else begin
                                        n.st = SR_WAIT;
                                    end
                                end
                                SR_ADDR: begin
                                    n.st = SR_DUMMY;
                                    n.bitn = r.ctrl[CTL_OCTAL] ? 6'(OPI_DUMMY)
                                        : 6'(SPI_DUMMY);
                                end
                                SR_DUMMY: begin
                                    n.st = SR_DATA;
                                    n.bitn = r.ctrl[CTL_OCTAL] ? 6'd4 : 6'd32;
                                end
                                default: n.st = SR_WAIT;  // see [RL16]
                            endcase
                        end
                        if (r.st == SR_ADDR && !r.ctrl[CTL_OCTAL] && r.bitn[2:0] == 3'd1) begin
                            n.sh = (r.bitn > 6'd16) ? r.addr[15:8] : r.addr[7:0];
                        end
                        // Next bit or byte goes out on the falling edge
                        if (r.ctrl[CTL_OCTAL]) begin
                            if (r.st == SR_CMD && r.bitn == 6'd2) begin
                                n.pins.dout = ~r.op;  // see [RL15]
                            end else if ((r.st == SR_CMD && r.op == OP_PARAM_RD)
                                || (r.st == SR_ADDR && r.bitn != 6'd1)) begin
                                // Four rotations leave the address register intact
                                n.pins.dout = r.addr[31:24];
                                n.addr = {r.addr[23:0], r.addr[31:24]};
                            end
                        end else begin
                            n.pins.dout = {7'h0, n.sh[7]};  // see [RL14]
                            n.sh = {n.sh[6:0], 1'b0};
                        end
                    end
                end
                n.pins.doe = (r.st == SR_DATA || r.st == SR_DUMMY) ? 8'h00
                    : (r.ctrl[CTL_OCTAL] ? 8'hFF : 8'h01);
            end
            SR_WAIT: begin
                n.pins.cs_n = 1'b1;
                n.pins.sclk = 1'b0;
                n.pins.doe = 8'h00;
                if (r.wait_cnt == 32'h0) begin
                    n.st = SR_IDLE;
                    // Arm is kept only by the arm opcode itself
                    n.reset_armed = (r.op == OP_RST_ARM);  // see [RL9] [RL10] [RL11]
                    if (r.op == OP_RST_EXEC && r.reset_armed) begin
                        n.program_suspend_flag = 1'b0;  // see [RL12]
                        n.erase_suspend_flag = 1'b0;
                        n.reset_armed = 1'b0;
                        n.wait_cnt = 32'(RESET_CYC);  // see [RL13]
                        n.st = SR_WAIT;
                        n.op = OP_NOP;
                    end
                    if (r.op == OP_RESUME) begin
                        n.program_suspend_flag = 1'b0;  // see [RL4] [RL5]
                        n.erase_suspend_flag = 1'b0;
                        n.wait_cnt = 32'(RESUME_CYC);  // see [RL6] [RL7] [RL8]
                        n.st = SR_WAIT;
                        n.op = OP_NOP;
                    end
                    if (r.op == OP_SUSPEND) begin
                        n.program_suspend_flag = r.ctrl[CTL_SUSP_P];  // see [RL18]
                        n.erase_suspend_flag = r.ctrl[CTL_SUSP_E];
                    end
                end else begin
                    n.wait_cnt = r.wait_cnt - 32'h1;
                end
            end
            default: n.st = SR_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
            r.pins.cs_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign wb_ack_o = r.ack;
    assign wb_dat_o = r.rdat;
    assign flash_sclk_o = r.pins.sclk;
    assign flash_cs_n_o = r.pins.cs_n;
    assign octal_data_lines_o = r.pins.dout;
    assign octal_data_lines_oe_o = r.pins.doe;

    ////////////////////////////////////////////////////////////////////////////
    gated_op_a: assert property (@(posedge mclk_i) disable iff (rst_i)  // see [RL20]
        (r.st == SR_IDLE && r.ctrl[CTL_GO] && !allowed) |=> r.st == SR_IDLE)
        else $error("rejected opcode started a frame");
    reject_flag_a: assert property (@(posedge mclk_i) disable iff (rst_i)  // see [RL20]
        (r.st == SR_IDLE && r.ctrl[CTL_GO] && !allowed) |=> r.rejected)
        else $error("rejected opcode not flagged");
    suspend_set_a: assert property (@(posedge mclk_i) disable iff (rst_i)  // see [RL18]
        (r.st == SR_WAIT && r.wait_cnt == 32'h0 && r.op == OP_SUSPEND)
        |=> r.program_suspend_flag == r.ctrl[CTL_SUSP_P] && r.erase_suspend_flag == r.ctrl[CTL_SUSP_E])
        else $error("suspend flags not taken from control");
    reset_wait_a: assert property (@(posedge mclk_i) disable iff (rst_i)  // see [RL13]
        (r.st == SR_WAIT && r.wait_cnt == 32'h0 && r.op == OP_RST_EXEC && r.reset_armed)
        |=> r.st == SR_WAIT && r.wait_cnt == 32'(RESET_CYC))
        else $error("reset recovery wait not started");
    resume_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i)  // see [RL4]
        (r.st == SR_WAIT && r.wait_cnt == 32'h0 && r.op == OP_RESUME) |=> !r.program_suspend_flag && !r.erase_suspend_flag)
        else $error("resume did not clear suspend flags");
    arm_cancel_a: assert property (@(posedge mclk_i) disable iff (rst_i)  // see [RL11]
        (r.st == SR_WAIT && r.wait_cnt == 32'h0 && r.op != OP_RST_ARM) |=> !r.reset_armed)
        else $error("reset arm survived another command");
    cs_idle_a: assert property (@(posedge mclk_i) disable iff (rst_i)  // see [RL16]
        (r.st == SR_IDLE) |-> r.pins.doe == 8'h00)
        else $error("driving lines while idle");
endmodule : srhc_host
`default_nettype wire

// ===== srhc_flash_model.sv
/* Behavioural flash device facing the host controller's pins.
   Assumes the bench says whether frames are single-line or octal STR. */
`default_nettype none
module srhc_flash_model
    import srhc_pkg::*;
#(
    parameter logic [31:0] PARAM_WORD = 32'hC3A5_1E96
) (
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic octal_i,
    input wire logic [7:0] din_i,
    output logic [7:0] dout_o,
    output logic [7:0] doe_o,
    output logic [31:0] addr_o,
    output int frames_o,
    output int resets_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int edges;
    int k;
    logic [63:0] sh;
    logic [7:0] op;
    logic [7:0] sec;
    logic armed;
    logic write_enable_latch;
    logic write_in_progress;
    initial begin
        {dout_o, doe_o, addr_o, sh, op, sec} = '0;
        {frames_o, resets_o, edges, armed, write_enable_latch, write_in_progress} = '0;
    end
    ////////////////////////////////////////////////////////////////////////////
    always @(negedge cs_n_i) edges = 0;
    always @(posedge sclk_i) begin
        if (!cs_n_i) begin
            sh = octal_i ? {sh[55:0], din_i} : {sh[62:0], din_i[0]};
            edges = edges + 1;
            if (!octal_i && edges == 8) op = sh[7:0];
            if (!octal_i && edges == 32) addr_o = {8'h00, sh[23:0]};
            if (octal_i && edges == 2) op = (sh[7:0] == ~sh[15:8]) ? sh[15:8] : 8'hEE;
            if (octal_i && edges == 6) addr_o = sh[31:0];
        end
    end
    // Data goes out on the falling edge so the host has half a period of setup
    always @(negedge sclk_i or posedge cs_n_i) begin
        k = edges - (octal_i ? 2 + OPI_ADDR_BYTES + OPI_DUMMY : 32 + SPI_DUMMY);
        if (!cs_n_i && op == OP_PARAM_RD && k >= 0 && k < (octal_i ? 4 : 32)) begin
            doe_o = octal_i ? 8'hFF : 8'h02;
            dout_o = octal_i ? PARAM_WORD[31 - 8 * k -: 8] : {6'h00, PARAM_WORD[31 - k], 1'b0};
        end else begin
            // Released lines keep toggling so stale data never looks valid
            doe_o = 8'h00;
            dout_o = ~dout_o;
        end
    end
    always @(posedge cs_n_i) begin
        if (edges >= (octal_i ? 2 : 8)) begin
            frames_o = frames_o + 1;
            if (op == OP_RST_EXEC && armed) begin
                resets_o = resets_o + 1;
                {write_enable_latch, write_in_progress, sec} = '0;
            end
            if (op == OP_RESUME && sec[ESB_BIT:PSB_BIT] != 2'b00) begin
                {write_enable_latch, write_in_progress} = 2'b11;
                sec[ESB_BIT:PSB_BIT] = 2'b00;
            end
            if (op == OP_SUSPEND && write_in_progress) begin
                write_enable_latch = 1'b0;
                sec[PSB_BIT] = 1'b1;
            end
            armed = (op == OP_RST_ARM); // Any other opcode drops the arm
        end
    end
endmodule : srhc_flash_model
`default_nettype wire

// ===== srhc_host_bench.sv
/* Self-checking bench: Wishbone tasks issue commands, the flash model answers.
   Assumes srhc_pkg, srhc_host and srhc_flash_model are compiled first. */
`default_nettype none
module srhc_host_bench
    import srhc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] WORD = 32'hC3A5_1E96;
    logic mclk_i;
    logic rst_i;
    logic req;
    logic we;
    logic ack;
    logic sclk;
    logic cs_n;
    logic octal;
    logic [3:0] adr;
    logic [31:0] wdat, rd_o, rdat, m_addr, extra;
    logic [7:0] h_out, h_oe, m_out, m_oe;
    int frames, resets, base, bad_count, checks_done;
    logic [7:0] free_op [6] = '{OP_WR_DIS, OP_STAT_RD, OP_CFG_RD, OP_SEC_RD, OP_SIG_RD, OP_NOP};
    logic [7:0] c2_op [5] = '{OP_CFG2_WR, OP_CFG2_WR, OP_CFG2_RD, OP_CFG2_RD, OP_CFG2_WR};
    logic [1:0] c2_hi [5] = '{A_HI_BLOCK, A_HI_FREE, 2'h0, 2'h1, 2'h0};
    logic c2_lat [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    logic [31:0] c2_exp [5] = '{32'h8000_0000, 32'h1, 32'h8000_0000, 32'h1, 32'h8000_0000};
    // Host enable wins; m_oe is ignored, so the model's toggling output shows whenever the host lets go
    wire [7:0] lines = (h_oe & h_out) | (~h_oe & m_out);
    srhc_host #(.RESUME_CYC(20), .RESET_CYC(20)) i_dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rd_o), .wb_ack_o(ack),
        .flash_sclk_o(sclk), .flash_cs_n_o(cs_n), .octal_data_lines_o(h_out),
        .octal_data_lines_oe_o(h_oe), .octal_data_lines_i(lines));
    srhc_flash_model #(.PARAM_WORD(WORD)) i_flash (
        .sclk_i(sclk), .cs_n_i(cs_n), .octal_i(octal), .din_i(lines), .dout_o(m_out),
        .doe_o(m_oe), .addr_o(m_addr), .frames_o(frames), .resets_o(resets));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge mclk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        check("ack", {31'h0, ack}, 32'h1);
        rdat = rd_o;
        req <= 1'b0;
        @(posedge mclk_i);
    endtask : xfer
    // Leaves the last status word in rdat once busy has dropped
    task automatic cmd(input logic [7:0] op, input logic lat);
        int n;
        n = 0;
        xfer(1'b1, REG_CTRL, (32'h1 << CTL_GO) | (32'(octal) << CTL_OCTAL)
            | (32'(lat) << CTL_LAT_OK) | extra | 32'(op));
        do begin
            xfer(1'b0, REG_STAT, 32'h0);
            n++;
        end while (rdat[0] !== 1'b0 && n < 400);
    endtask : cmd
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    initial begin
        repeat (60000) @(posedge mclk_i);
        bad_count++;
        complete_run();
    end
    initial begin
        {req, we, adr, wdat, octal, bad_count, checks_done, extra} = '0;
        rst_i = 1'b1;
        repeat (10) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        for (int m = 0; m < 2; m++) begin
            octal = m[0];
            xfer(1'b1, REG_ADDR, 32'h10 << m);
            cmd(OP_PARAM_RD, 1'b0);
            xfer(1'b0, REG_DATA, 32'h0);
            check("param data", rdat, WORD);
            check("param addr", m_addr, 32'h10 << m);
            check("released", {24'h0, h_oe, cs_n}, 32'h1);
            check("model released", {24'h0, m_oe}, 32'h0);
        end
        octal = 1'b0;
        for (int t = PSB_BIT; t <= ESB_BIT; t++) begin
            xfer(1'b1, REG_STAT, 32'h1 << t);
            base = frames;
            cmd(OP_PARAM_RD, 1'b0);
            check("early read", {rdat[4], rdat[t], 30'(frames - base)}, 32'hC000_0000);
            xfer(1'b1, REG_STAT, 32'h1 << t);
            cmd(OP_RESUME, 1'b1);
            check("resume", {rdat[4], rdat[t], 30'(frames - base)}, 32'h1);
            repeat (30) @(posedge mclk_i);
        end
        xfer(1'b1, REG_STAT, 32'h1 << PSB_BIT);
        for (int i = 0; i < 6; i++) begin
            base = frames;
            cmd(free_op[i], 1'b0);
            check("free opcode", {rdat[4], 31'(frames - base)}, 32'h1);
        end
        for (int i = 0; i < 5; i++) begin
            xfer(1'b1, REG_STAT, 32'h1 << PSB_BIT);
            xfer(1'b1, REG_ADDR, {c2_hi[i], 30'h0});
            base = frames;
            cmd(c2_op[i], c2_lat[i]);
            check("config2 gate", {rdat[4], 31'(frames - base)}, c2_exp[i]);
        end
        xfer(1'b1, REG_STAT, 32'h0);
        cmd(OP_RST_ARM, 1'b0);
        check("armed", {31'h0, rdat[1]}, 32'h1);
        cmd(OP_NOP, 1'b0);
        check("nop disarms", {31'h0, rdat[1]}, 32'h0);
        base = resets;
        cmd(OP_RST_EXEC, 1'b0);
        check("lone reset", 32'(resets - base), 32'h0);
        xfer(1'b1, REG_STAT, 32'h0);
        cmd(OP_RST_ARM, 1'b0);
        cmd(OP_RST_EXEC, 1'b0);
        check("reset done", {rdat[1:0], 30'(resets - base)}, 32'h1);
        extra = 32'h1 << CTL_SUSP_E;
        cmd(OP_SUSPEND, 1'b0);
        extra = 32'h0;
        check("suspend flag", {28'h0, rdat[3:0]}, 32'h8);
        complete_run();
    end
endmodule : srhc_host_bench
`default_nettype wire
